// File: rtl/tws_regs.vh
// register map, field positions, status codes and timing for the
// two-wire master sequencer; assumes a 10 MHz system clock
`ifndef TWS_REGS_VH
`define TWS_REGS_VH

// register indices on the plain register port
`define TWS_ADDR_CTRL 2'h0
`define TWS_ADDR_STAT 2'h1
`define TWS_ADDR_DATA 2'h2

// bus_control bit positions
`define TWS_B_FLAG 7
`define TWS_B_ACK 6
`define TWS_B_STA 5
`define TWS_B_STO 4
`define TWS_B_WCOL 3
`define TWS_B_EN 2
`define TWS_B_IE 0

// bus_status_reg status codes, prescaler bits zero
`define TWS_ST_START 8'h08
`define TWS_ST_RSTART 8'h10
`define TWS_ST_AW_ACK 8'h18
`define TWS_ST_AW_NACK 8'h20
`define TWS_ST_DW_ACK 8'h28
`define TWS_ST_DW_NACK 8'h30
`define TWS_ST_ARB 8'h38
`define TWS_ST_AR_ACK 8'h40
`define TWS_ST_AR_NACK 8'h48
`define TWS_ST_DR_ACK 8'h50
`define TWS_ST_DR_NACK 8'h58
`define TWS_ST_IDLE 8'hF8

// reset values
`define TWS_CTRL_RST 8'h00
`define TWS_DATA_RST 8'hFF

// quarter bit time and system clock period
`define TWS_QTR_NS 2500
`define TWS_CLK_NS 100

// bit engine: last phase of a bit and index of the acknowledge bit
`define TWS_PH_LAST 2'h3
`define TWS_ACK_BIT 4'h8

`endif

// File: rtl/tws_master.v
// two-wire master sequencer: start, address, transmit and receive
// bytes, stop and repeated start behind three byte-wide registers.
// assumes one system clock; scl and sda are open-drain pins resolved
// outside, and both are asynchronous to clk.
//
// Functional notes
// - after a transmitted data byte, post 0x28 on ack, 0x30 on nack; then accept next step
// - flag cleared with stop only: send stop, clear stop request itself
// - flag cleared with start and stop: stop, then start, clear stop request
// - arbitration lost in write address or data: 0x38; plain clear releases bus
// - after arbitration loss, clear with start: wait for free bus, then start
// - master only after start; address direction bit picks transmit or receive
// - start waits until the bus is free, never over another master
// - once start is sent, set flag and post 0x08
// - flag clears by writing one together with the enable bit; clearing continues the transfer
// - after read address and ack bit, set flag with 0x38, 0x40 or 0x48
// - received byte stays valid in data register while flag is set
// - start while owning bus is a repeated start and posts 0x10
// - data write with flag low is dropped and sets write collision
`timescale 1ns/1ps
`include "tws_regs.vh"

module tws_master #(
	parameter [15:0] QTR_CYC = (`TWS_QTR_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS
) (
	input wire clk,
	input wire rst_n,
	input wire ce,
	input wire [1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire scl_in,
	output wire scl_out,
	output wire scl_oe_n,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe_n,
	output wire irq
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_WFREE = 3'h1;
	localparam [2:0] ST_START = 3'h2;
	localparam [2:0] ST_STOP = 3'h3;
	localparam [2:0] ST_BYTE = 3'h4;

	// decoding shared by the read and write paths
	function hit;
		input [1:0] a;
		input [1:0] r;
		begin
			hit = (a == r);
		end
	endfunction

	// two-stage synchronisers for the scl and sda pins
	wire [1:0] pin_in = {scl_in, sda_in};
	wire [1:0] pin_s;
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : sync
			reg m_r;
			reg s_r;
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					m_r <= 1'b1;
					s_r <= 1'b1;
				end else if (ce) begin
					m_r <= pin_in[g];
					s_r <= m_r;
				end
			end
			assign pin_s[g] = s_r;
		end
	endgenerate
	wire scl_s = pin_s[1];
	wire sda_s = pin_s[0];

	reg sda_p_r;
	reg busy_r;
	// bus monitor: start/stop seen by sda edges while scl high
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_p_r <= 1'b1;
			busy_r <= 1'b0;
		end else if (ce) begin
			sda_p_r <= sda_s;
			if (scl_s && sda_p_r && !sda_s)
				busy_r <= 1'b1;
			else if (scl_s && !sda_p_r && sda_s)
				busy_r <= 1'b0;
		end
	end

	reg flag_r;
	reg ack_r;
	reg sta_r;
	reg sto_r;
	reg wcol_r;
	reg en_r;
	reg ie_r;
	reg [1:0] presc_r;
	reg [7:0] code_r;
	reg [7:0] data_r;
	reg go_r;
	reg [2:0] state_r;
	reg [1:0] ph_r;
	reg [3:0] bit_r;
	reg [15:0] cnt_r;
	reg [7:0] shift_r;
	reg scl_low_r;
	reg sda_low_r;
	reg owner_r;
	reg addr_pend_r;
	reg rx_mode_r;
	reg rstart_r;
	reg ack_seen_r;

	wire wr_ctrl = reg_wr && hit(reg_addr, `TWS_ADDR_CTRL);
	wire wr_stat = reg_wr && hit(reg_addr, `TWS_ADDR_STAT);
	wire wr_data = reg_wr && hit(reg_addr, `TWS_ADDR_DATA);

	// prescaler stretches the quarter bit by four per step
	wire [15:0] qlim = QTR_CYC << {presc_r, 1'b0};
	// hold the phase timer while scl is released but still low,
	// so a slave stretching the clock slows the whole sequence
	wire stretch = !scl_low_r && !scl_s;
	wire busy_act = (state_r == ST_START) || (state_r == ST_STOP) ||
		(state_r == ST_BYTE);
	wire tick = busy_act && !stretch && (cnt_r >= qlim - 16'h0001);
	wire tx_now = addr_pend_r || !rx_mode_r;

	// open-drain pins: output is always low, enable low while pulling
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_n = !scl_low_r;
	assign sda_oe_n = !sda_low_r;
	assign irq = ie_r && flag_r;

	// register writes, sequencer and bit engine
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{flag_r, ack_r, sta_r, sto_r, wcol_r, en_r, ie_r} <= 7'h00;
			presc_r <= 2'h0;
			code_r <= `TWS_ST_IDLE;
			data_r <= `TWS_DATA_RST;
			go_r <= 1'b0;
			state_r <= ST_IDLE;
			ph_r <= 2'h0;
			bit_r <= 4'h0;
			cnt_r <= 16'h0000;
			shift_r <= 8'h00;
			scl_low_r <= 1'b0;
			sda_low_r <= 1'b0;
			owner_r <= 1'b0;
			addr_pend_r <= 1'b0;
			rx_mode_r <= 1'b0;
			rstart_r <= 1'b0;
			ack_seen_r <= 1'b0;
		end else if (ce) begin
			// software side; hardware sets below win over a clear
			if (wr_ctrl) begin
				ack_r <= reg_wdata[`TWS_B_ACK];
				sta_r <= reg_wdata[`TWS_B_STA];
				sto_r <= reg_wdata[`TWS_B_STO];
				en_r <= reg_wdata[`TWS_B_EN];
				ie_r <= reg_wdata[`TWS_B_IE];
				if (reg_wdata[`TWS_B_FLAG] && reg_wdata[`TWS_B_EN]) begin
					flag_r <= 1'b0;
					go_r <= 1'b1;
				end
			end
			if (wr_stat)
				presc_r <= reg_wdata[1:0];
			if (wr_data) begin
				if (flag_r) begin
					data_r <= reg_wdata;
					wcol_r <= 1'b0;
				end else begin
					wcol_r <= 1'b1;
				end
			end
			cnt_r <= (!busy_act || tick) ? 16'h0000 :
				(stretch ? cnt_r : cnt_r + 16'h0001);
			if (tick)
				ph_r <= ph_r + 2'h1;

			if (wr_ctrl && !reg_wdata[`TWS_B_EN]) begin
				// disabled: drop the sequence, pending step and ownership and let go of the bus; flag and status keep their values
				state_r <= ST_IDLE;
				go_r <= 1'b0;
				owner_r <= 1'b0;
				scl_low_r <= 1'b0;
				sda_low_r <= 1'b0;
			end else begin
				case (state_r)
				ST_IDLE: begin
					if (go_r) begin
						go_r <= 1'b0;
						ph_r <= 2'h0;
						bit_r <= 4'h0;
						if (sto_r && owner_r) begin
							state_r <= ST_STOP;
						end else if (sto_r) begin
							sto_r <= 1'b0;
							state_r <= sta_r ? ST_WFREE : ST_IDLE;
						end else if (sta_r) begin
							// repeated start keeps the bus, else wait for it
							state_r <= owner_r ? ST_START : ST_WFREE;
						end else if (owner_r) begin
							shift_r <= data_r;
							state_r <= ST_BYTE;
						end else begin
							// lost arbitration earlier: stay released
							code_r <= `TWS_ST_IDLE;
						end
					end
				end
				ST_WFREE: begin
					ph_r <= 2'h0;
					if (!busy_r)
						state_r <= ST_START;
				end
				ST_START: begin
					if (tick) begin
						case (ph_r)
						2'h0: sda_low_r <= 1'b0;
						2'h1: scl_low_r <= 1'b0;
						2'h2: sda_low_r <= 1'b1;
						default: begin
							scl_low_r <= 1'b1;
							rstart_r <= owner_r;
							owner_r <= 1'b1;
							addr_pend_r <= 1'b1;
							flag_r <= 1'b1;
							code_r <= owner_r ? `TWS_ST_RSTART :
								`TWS_ST_START;
							state_r <= ST_IDLE;
						end
						endcase
					end
				end
				ST_STOP: begin
					if (tick) begin
						case (ph_r)
						2'h0: sda_low_r <= 1'b1;
						2'h1: scl_low_r <= 1'b0;
						2'h2: sda_low_r <= 1'b0;
						default: begin
							// stop request clears itself; a start may follow
							sto_r <= 1'b0;
							owner_r <= 1'b0;
							addr_pend_r <= 1'b0;
							state_r <= sta_r ? ST_WFREE : ST_IDLE;
						end
						endcase
					end
				end
				ST_BYTE: begin
					if (tick) begin
						case (ph_r)
						2'h0: begin
							if (bit_r == `TWS_ACK_BIT)
								sda_low_r <= !tx_now && ack_r;
							else
								sda_low_r <= tx_now && !shift_r[7];
						end
						2'h1: scl_low_r <= 1'b0;
						2'h2: begin
							if (bit_r == `TWS_ACK_BIT) begin
								ack_seen_r <= !sda_s;
							end else if (tx_now && shift_r[7] && !sda_s) begin
								// another master pulled sda low: back off
								sda_low_r <= 1'b0;
								owner_r <= 1'b0;
								addr_pend_r <= 1'b0;
								flag_r <= 1'b1;
								code_r <= `TWS_ST_ARB;
								state_r <= ST_IDLE;
							end
							if (bit_r != `TWS_ACK_BIT)
								shift_r <= {shift_r[6:0], sda_s};
						end
						default: begin
							scl_low_r <= 1'b1;
							bit_r <= bit_r + 4'h1;
							if (bit_r == `TWS_ACK_BIT) begin
								sda_low_r <= 1'b0;
								flag_r <= 1'b1;
								state_r <= ST_IDLE;
								addr_pend_r <= 1'b0;
								if (addr_pend_r) begin
									rx_mode_r <= data_r[0];
									if (data_r[0])
										code_r <= ack_seen_r ? `TWS_ST_AR_ACK :
											`TWS_ST_AR_NACK;
									else
										code_r <= ack_seen_r ? `TWS_ST_AW_ACK :
											`TWS_ST_AW_NACK;
								end else if (rx_mode_r) begin
									data_r <= shift_r;
									code_r <= ack_r ? `TWS_ST_DR_ACK : `TWS_ST_DR_NACK;
								end else begin
									code_r <= ack_seen_r ? `TWS_ST_DW_ACK :
										`TWS_ST_DW_NACK;
								end
							end
						end
						endcase
					end
				end
				default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// read data one cycle after the strobe; code_r only moves at the
	// end of a bus action or on a clear without the bus, so status is stable while it runs
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (ce) begin
			if (reg_rd) begin
				if (hit(reg_addr, `TWS_ADDR_CTRL))
					reg_rdata <= {flag_r, ack_r, sta_r, sto_r, wcol_r, en_r, 1'b0, ie_r};
				else if (hit(reg_addr, `TWS_ADDR_STAT))
					reg_rdata <= {code_r[7:3], 1'b0, presc_r};
				else if (hit(reg_addr, `TWS_ADDR_DATA))
					reg_rdata <= data_r;
				else
					reg_rdata <= 8'h00;
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

endmodule

// File: verification/tws_master_properties.sv
// checker for the master's register port and bus pins
// bound to tws_master; one clock, async active-low reset
`timescale 1ns/1ps
module tws_props #(
	parameter [15:0] QTR_CYC = 16'h0019
) (
	input wire clk,
	input wire rst_n,
	input wire [1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire scl_out,
	input wire scl_oe_n,
	input wire sda_out,
	input wire sda_oe_n,
	input wire irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// stop: sda let go while scl stays high
	sequence s_stop;
		$rose(sda_oe_n) && scl_oe_n && $past(scl_oe_n);
	endsequence
	sequence s_rd(a);
		$past(reg_rd && reg_addr == a);
	endsequence
	a_ctrl_rsvd: assert property (s_rd(2'h0) |-> !reg_rdata[1])
		else $error("reserved bit set");
	a_stat_zero: assert property (s_rd(2'h1) |-> !reg_rdata[2])
		else $error("status bit two set");
	a_stat_code: assert property (s_rd(2'h1)
		|-> reg_rdata[7:3] inside {[5'h01:5'h0B], 5'h1F})
		else $error("bad status code");
	a_open_drain: assert property (!scl_out && !sda_out)
		else $error("pin driven high");
	a_scl_low: assert property ($fell(scl_oe_n) |-> !scl_oe_n [*2])
		else $error("scl low too short");
	a_scl_high: assert property ($rose(scl_oe_n) |-> scl_oe_n [*2])
		else $error("scl high too short");
	a_stop_quiet: assert property (s_stop |-> !$rose(irq) [*4])
		else $error("flag after stop");
	a_flag_clear: assert property (reg_wr && reg_addr == 2'h0 && reg_wdata[7]
		|-> ##2 !irq) else $error("flag not cleared");
endmodule
bind tws_master tws_props #(.QTR_CYC(QTR_CYC)) u_props (.clk(clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .irq(irq));

// File: verification/tws_slave.sv
// behavioural bus slave: acks its address, takes written bytes, sends tx_byte
// on reads; assumes pull-ups, so a released line reads high
`timescale 1ns/1ps
module tws_slave #(
	parameter [6:0] OWN_ADDR = 7'h2A
) (
	input wire scl,
	input wire sda,
	input wire [7:0] tx_byte,
	input wire nack_data,
	output reg sda_pull,
	output reg [7:0] rx_byte
);
	reg [3:0] cnt_r = 4'h0;
	reg [7:0] sh_r = 8'h00;
	reg [7:0] tx_r = 8'h00;
	reg act_r = 1'b0, adr_r = 1'b0, rd_r = 1'b0, snd_r = 1'b0, mack_r = 1'b0;
	initial {sda_pull, rx_byte} = 9'h000;
	// start: sda falls while scl high
	always @(negedge sda) if (scl) begin
		act_r = 1'b1;
		adr_r = 1'b1;
		snd_r = 1'b0;
		cnt_r = 4'h0;
	end
	// stop ends the frame
	always @(posedge sda) if (scl) act_r = 1'b0;
	// sample on scl rise; ninth bit is the master's ack
	always @(posedge scl) if (act_r) begin
		if (cnt_r < 4'h8) sh_r = {sh_r[6:0], sda};
		else mack_r = !sda;
		cnt_r = cnt_r + 4'h1;
	end
	// change sda only while scl is low, so no false start or stop
	always @(negedge scl) if (act_r) begin
		if (cnt_r == 4'h8) begin
			rd_r = adr_r ? sh_r[0] : rd_r;
			act_r = !adr_r || sh_r[7:1] == OWN_ADDR;
			if (!adr_r && !rd_r) rx_byte = sh_r;
			sda_pull = adr_r ? act_r : !rd_r && !nack_data;
		end else if (cnt_r == 4'h9) begin
			cnt_r = 4'h0;
			snd_r = rd_r && (adr_r || mack_r);
			adr_r = 1'b0;
			tx_r = tx_byte;
			sda_pull = snd_r && !tx_r[7];
		end else if (snd_r) begin
			tx_r = {tx_r[6:0], 1'b1};
			sda_pull = !tx_r[7];
		end
	end
endmodule

// File: verification/tb.sv
// bench for the two-wire master: register port tasks, one slave model,
// and a pull on sda standing in for a rival master
`timescale 1ns/1ps
module tb;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg ce = 1'b1;
	reg [1:0] reg_addr = 2'h0;
	reg [7:0] reg_wdata = 8'h00;
	reg reg_wr = 1'b0, reg_rd = 1'b0, arb_pull = 1'b0, nack_data = 1'b0;
	wire [7:0] reg_rdata, rx_byte;
	wire scl_out, scl_oe_n, sda_out, sda_oe_n, irq, sda_pull;
	// wired-and lines with pull-ups
	wire scl = scl_oe_n | scl_out;
	wire sda = (sda_oe_n | sda_out) & !sda_pull & !arb_pull;
	integer fails = 0, tests_run = 0, i, k;
	reg [31:0] row;
	reg [31:0] rows [0:9];
	// 100 ns clock
	initial forever #50 clk = !clk;
	tws_master #(.QTR_CYC(16'h0002)) dut (.clk(clk), .rst_n(rst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
	tws_slave sl (.scl(scl), .sda(sda), .tx_byte(8'hA7), .nack_data(nack_data),
		.sda_pull(sda_pull), .rx_byte(rx_byte));
	task chk(input [7:0] got, input [7:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input [1:0] a, input [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [1:0] a, input [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// bounded wait for the flag, seen through irq with its enable set
	task wait_flag;
		repeat (3) @(posedge clk);
		#1;
		for (i = 0; i < 900 && irq !== 1'b1; i = i + 1) #100;
		chk({7'h00, irq}, 8'h01);
	endtask
	task step(input [7:0] c);
		wr(2'h0, c);
		wait_flag;
	endtask
	task report_and_stop;
		if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// twenty thousand cycles, several times the expected run
	initial begin
		#2000000;
		fails = fails + 1;
		report_and_stop;
	end
	initial begin
		rows[0] = 32'h00A50800;
		rows[1] = 32'h54C51801;
		rows[2] = 32'h3CC52801;
		rows[3] = 32'h3CC53003;
		rows[4] = 32'h00A51000;
		rows[5] = 32'h55C54001;
		rows[6] = 32'h00C55000;
		rows[7] = 32'h00855800;
		rows[8] = 32'h00B50800;
		rows[9] = 32'h57C54801;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(2'h0, 8'h00);
		rd(2'h1, 8'hF8);
		rd(2'h2, 8'hFF);
		rd(2'h3, 8'h00);
		// row: data to load, control write, status expected, flags
		for (k = 0; k < 10; k = k + 1) begin
			row = rows[k];
			nack_data <= row[1];
			if (row[0]) wr(2'h2, row[31:24]);
			step(row[23:16]);
			rd(2'h1, row[15:8]);
			if (row[15:8] == 8'h28) chk(rx_byte, 8'h3C);
			if (row[15:8] > 8'h48) rd(2'h2, 8'hA7);
		end
		// irq off with its enable; stop clears its own request
		wr(2'h0, 8'h04);
		rd(2'h0, 8'h84);
		chk({7'h00, irq}, 8'h00);
		wr(2'h0, 8'h95);
		repeat (40) @(posedge clk);
		rd(2'h0, 8'h05);
		wr(2'h2, 8'h11);
		rd(2'h0, 8'h0D);
		// rival holds sda low through the address byte
		step(8'hA5);
		wr(2'h2, 8'h80);
		rd(2'h0, 8'hA5);
		arb_pull <= 1'b1;
		step(8'hC5);
		rd(2'h1, 8'h38);
		wr(2'h0, 8'h85);
		rd(2'h1, 8'hF8);
		wr(2'h0, 8'hA5);
		repeat (100) @(posedge clk);
		rd(2'h1, 8'hF8);
		arb_pull <= 1'b0;
		wait_flag;
		rd(2'h1, 8'h08);
		// a write while ce is low must be frozen out entirely
		ce <= 1'b0;
		wr(2'h0, 8'h00);
		ce <= 1'b1;
		rd(2'h0, 8'hA5);
		report_and_stop;
	end
endmodule
